// ### verilog/seq_wave_gen.sv
`timescale 1ns/10ps
`default_nettype none

// ********************************
// one counter digit
// ********************************
module seq_digit (
	input  wire logic                       clk,       // system clock
	input  wire logic                       clr_rst_b, // reset or clear, low
	input  wire logic                       en_in,     // incoming count enable
	input  wire seq_wave_pkg::seq_mode_type mode,      // code sequence
	input  wire logic                       down,      // count direction
	input  wire logic [3:0]                 tc,        // terminal count code
	output logic [3:0]                      code_q,    // visible digit
	output logic                            en_out     // enable to next digit
);
	import seq_wave_pkg::*;

	logic [3:0] code_d;
	logic [3:0] idx;
	logic [3:0] last;
	logic       found;

	// next code: locate position, step, map back
	always_comb begin
		last  = seq_last(mode);
		idx   = 4'h0;
		found = 1'b0;
		for (int i = 0; i < 16; i++) begin
			if (4'(i) <= last && seq_code(mode, 4'(i)) == code_q) begin
				idx   = 4'(i);
				found = 1'b1;
			end
		end
		code_d = code_q;
		if (en_in) begin
			if (!found) begin
				// codes outside a ten-state sequence fall into its start
				code_d = seq_code(mode, 4'h0);
			end else if (down) begin
				code_d = seq_code(mode, (idx == 4'h0) ? last : idx - 4'h1);
			end else begin
				code_d = seq_code(mode, (idx == last) ? 4'h0 : idx + 4'h1);
			end
		end
	end

	// clear needs no clock edge
	always_ff @(posedge clk or negedge clr_rst_b) begin
		if (!clr_rst_b) begin
			code_q <= 4'h0;
		end else begin
			code_q <= code_d;
		end
	end

	assign en_out = en_in & (code_q == tc);

	// ********************************
	// digit checks
	// ********************************

	// an edge that still sees clear low is no step, so the step antecedents want clear high; hold_when_idle_a and digit_clear_a do not
	hold_when_idle_a : assert property (@(posedge clk) disable iff (!clr_rst_b)
		!en_in |=> $stable(code_q))
		else $error("digit changed while enable low");

	gray_one_bit_a : assert property (@(posedge clk) disable iff (!clr_rst_b)
		(clr_rst_b && en_in && $stable(mode)
		&& (mode == SEQ_GRAY || mode == SEQ_EXCESS_THREE_REFLECTED))
		|=> $countones(code_q ^ $past(code_q)) == 1)
		else $error("gray step changed other than one bit");

	binary_step_a : assert property (@(posedge clk) disable iff (!clr_rst_b)
		(clr_rst_b && en_in && !down && mode == SEQ_BINARY)
		|=> code_q == $past(code_q) + 4'h1)
		else $error("binary step wrong");

	x3_range_a : assert property (@(posedge clk) disable iff (!clr_rst_b)
		(clr_rst_b && en_in && mode == SEQ_EXCESS_THREE_PLAIN && $stable(mode))
		|=> code_q >= 4'h3 && code_q <= 4'hc)
		else $error("excess-three code out of range");

	binary_wrap_a : assert property (@(posedge clk) disable iff (!clr_rst_b)
		(clr_rst_b && en_in && !down && mode == SEQ_BINARY && code_q == 4'hf)
		|=> code_q == 4'h0)
		else $error("binary count did not wrap to zero");

	down_step_a : assert property (@(posedge clk) disable iff (!clr_rst_b)
		(clr_rst_b && en_in && down && mode == SEQ_BINARY)
		|=> code_q == $past(code_q) - 4'h1)
		else $error("binary down step wrong");

	gray_start_a : assert property (@(posedge clk) disable iff (!clr_rst_b)
		(clr_rst_b && en_in && !down && mode == SEQ_GRAY && code_q == 4'h0)
		|=> code_q == 4'h1)
		else $error("gray count left start wrongly");

	gray_wrap_a : assert property (@(posedge clk) disable iff (!clr_rst_b)
		(clr_rst_b && en_in && !down && mode == SEQ_GRAY && code_q == 4'h8)
		|=> code_q == 4'h0)
		else $error("gray count did not wrap to start");

	x3_wrap_a : assert property (@(posedge clk) disable iff (!clr_rst_b)
		(clr_rst_b && en_in && !down && mode == SEQ_EXCESS_THREE_PLAIN && code_q == 4'hc)
		|=> code_q == 4'h3)
		else $error("excess-three count did not wrap");

	x3_refl_start_a : assert property (@(posedge clk) disable iff (!clr_rst_b)
		(clr_rst_b && en_in && mode == SEQ_EXCESS_THREE_REFLECTED && code_q == 4'h0)
		|=> code_q == 4'h2)
		else $error("reflected excess-three did not enter start");

	x3_refl_wrap_a : assert property (@(posedge clk) disable iff (!clr_rst_b)
		(clr_rst_b && en_in && !down && mode == SEQ_EXCESS_THREE_REFLECTED && code_q == 4'ha)
		|=> code_q == 4'h2)
		else $error("reflected excess-three did not wrap");

	digit_clear_a : assert property (@(posedge clk)
		(!clr_rst_b && !$past(clr_rst_b))
		|-> code_q == 4'h0)
		else $error("digit not zero during clear");

endmodule // seq_digit

// ********************************
// top: two digits and waveform generator
// ********************************
module seq_wave_gen (
	input  wire logic                       CLK,        // 200 MHz clock
	input  wire logic                       RST_B,      // async reset, low
	input  wire logic                       CLR_B,      // async clear, low
	input  wire logic                       CNT_EN,     // counter enable
	input  wire logic                       WAVE_EN,    // waveform enable
	input  wire logic [seq_wave_pkg::ADDR_W-1:0] ADDR,  // register address
	input  wire logic [seq_wave_pkg::DATA_W-1:0] WDATA, // write data
	input  wire logic                       WR,         // write strobe
	input  wire logic                       RD,         // read strobe
	output logic [seq_wave_pkg::DATA_W-1:0] RDATA,      // read data, next cycle
	output logic [3:0]                      DIGIT0,     // low digit code
	output logic [3:0]                      DIGIT1,     // high digit code
	output logic                            CARRY,      // cascade enable out
	output logic [4:0]                      LFSR_STATE, // sequence state bits
	output logic                            WAVE_OUT    // registered waveform
);
	import seq_wave_pkg::*;

	logic        clr_rst_b;
	cfg_type     cfg_q;
	cfg_type     cfg_d;
	logic [31:0] rdata_q;
	logic [31:0] rdata_d;
	logic        en1;
	logic [4:0]  lfsr_state_bits_q;
	logic [4:0]  lfsr_state_bits_d;
	logic        waveform_output_reg_q;
	logic        waveform_output_reg_d;
	logic [4:0]  slot;

	// clear acts on counter and sequence state, config survives it
	assign clr_rst_b = RST_B & CLR_B;

	// ********************************
	// counter digits
	// ********************************
	seq_digit u_digit0 (
		.clk       (CLK),
		.clr_rst_b (clr_rst_b),
		.en_in     (CNT_EN),
		.mode      (cfg_q.mode),
		.down      (cfg_q.down),
		.tc        (cfg_q.tc0),
		.code_q    (DIGIT0),
		.en_out    (en1)
	);

	seq_digit u_digit1 (
		.clk       (CLK),
		.clr_rst_b (clr_rst_b),
		.en_in     (en1),
		.mode      (cfg_q.mode),
		.down      (cfg_q.down),
		.tc        (cfg_q.tc1),
		.code_q    (DIGIT1),
		.en_out    (CARRY)
	);

	// ********************************
	// waveform generator
	// ********************************

	// time slot of a state: walk the feedback sequence from the start
	function automatic logic [4:0] slot_of(input logic [4:0] s);
		logic [4:0] p;
		p       = WAVE_START;
		slot_of = 5'h00;
		for (int k = 0; k < 32; k++) begin
			if (p == s) begin
				slot_of = 5'(k);
			end
			p = {p[3:0], wave_fb(p)};
		end
	endfunction

	// feedback plus early return gives the modulus; no state is stranded
	always_comb begin
		slot                  = slot_of(lfsr_state_bits_q);
		lfsr_state_bits_d     = lfsr_state_bits_q;
		waveform_output_reg_d = waveform_output_reg_q;
		if (WAVE_EN) begin
			if (slot >= cfg_q.last) begin
				lfsr_state_bits_d = WAVE_START;
			end else begin
				lfsr_state_bits_d = {lfsr_state_bits_q[3:0], wave_fb(lfsr_state_bits_q)};
			end
			// decode registered so the pin never sees decode glitches
			waveform_output_reg_d = cfg_q.table_bits[slot];
		end
	end

	always_ff @(posedge CLK or negedge clr_rst_b) begin
		if (!clr_rst_b) begin
			lfsr_state_bits_q     <= WAVE_START;
			waveform_output_reg_q <= 1'b0;
		end else begin
			lfsr_state_bits_q     <= lfsr_state_bits_d;
			waveform_output_reg_q <= waveform_output_reg_d;
		end
	end

	assign LFSR_STATE = lfsr_state_bits_q;
	assign WAVE_OUT   = waveform_output_reg_q;

	// ********************************
	// register port
	// ********************************

	// writes to config; status and unmapped addresses ignore writes
	always_comb begin
		cfg_d = cfg_q;
		if (WR) begin
			case (ADDR)
				ADDR_CNT_CTRL: begin
					cfg_d.mode = seq_mode_type'(WDATA[1:0]);
					cfg_d.down = WDATA[CTRL_DOWN_BIT];
				end
				ADDR_CNT_TC: begin
					cfg_d.tc0 = WDATA[3:0];
					cfg_d.tc1 = WDATA[7:4];
				end
				ADDR_WAVE_LAST: cfg_d.last       = WDATA[4:0];
				ADDR_WAVE_TBL:  cfg_d.table_bits = WDATA;
				default:        cfg_d            = cfg_q;
			endcase
		end
	end

	// read data valid only in the cycle after the strobe
	always_comb begin
		rdata_d = 32'h0000_0000;
		if (RD) begin
			case (ADDR)
				ADDR_CNT_CTRL:  rdata_d = {29'h0, cfg_q.down, cfg_q.mode};
				ADDR_CNT_TC:    rdata_d = {24'h0, cfg_q.tc1, cfg_q.tc0};
				ADDR_WAVE_LAST: rdata_d = {27'h0, cfg_q.last};
				ADDR_WAVE_TBL:  rdata_d = cfg_q.table_bits;
				ADDR_STATUS: begin
					rdata_d                           = {16'h0, 3'h0, lfsr_state_bits_q,
						DIGIT1, DIGIT0};
					rdata_d[STAT_SLOT_LSB +: 5]        = slot;
					rdata_d[STAT_WAVE_BIT]             = waveform_output_reg_q;
				end
				default:        rdata_d = 32'h0000_0000;
			endcase
		end
	end

	// config is reset only by the chip reset, not by clear
	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			cfg_q.mode       <= MODE_RST;
			cfg_q.down       <= 1'b0;
			cfg_q.tc0        <= TC_RST;
			cfg_q.tc1        <= TC_RST;
			cfg_q.last       <= WAVE_LAST_RST;
			cfg_q.table_bits <= WAVE_TBL_RST;
			rdata_q          <= 32'h0000_0000;
		end else begin
			cfg_q   <= cfg_d;
			rdata_q <= rdata_d;
		end
	end

	assign RDATA = rdata_q;

	// ********************************
	// checks
	// ********************************

	wave_freeze_a : assert property (@(posedge CLK) disable iff (!clr_rst_b)
		!WAVE_EN |=> $stable(lfsr_state_bits_q) && $stable(waveform_output_reg_q))
		else $error("waveform moved while paused");

	wave_lag_a : assert property (@(posedge CLK) disable iff (!clr_rst_b)
		(clr_rst_b && WAVE_EN && $stable(cfg_q.table_bits))
		|=> waveform_output_reg_q == cfg_q.table_bits[slot_of($past(lfsr_state_bits_q))])
		else $error("waveform output not one clock behind decode");

	wave_wrap_a : assert property (@(posedge CLK) disable iff (!clr_rst_b)
		(WAVE_EN && slot >= cfg_q.last) |=> lfsr_state_bits_q == WAVE_START)
		else $error("sequence did not return to start");

	wave_shift_a : assert property (@(posedge CLK) disable iff (!clr_rst_b)
		(clr_rst_b && WAVE_EN && slot < cfg_q.last)
		|=> lfsr_state_bits_q[4:1] == $past(lfsr_state_bits_q[3:0]) && slot == $past(slot) + 5'h01)
		else $error("shift step or slot advance wrong");

	clear_start_a : assert property (@(posedge CLK)
		$rose(clr_rst_b) |-> lfsr_state_bits_q == WAVE_START && slot == 5'h00)
		else $error("clear did not give slot zero");

	carry_and_a : assert property (@(posedge CLK) disable iff (!clr_rst_b)
		CARRY == (CNT_EN && DIGIT0 == cfg_q.tc0 && DIGIT1 == cfg_q.tc1))
		else $error("cascade enable wrong");

	read_once_a : assert property (@(posedge CLK) disable iff (!RST_B)
		(RD && ADDR == ADDR_STATUS) |=> RDATA[7:0] == {$past(DIGIT1), $past(DIGIT0)})
		else $error("status read wrong");

	// cascade: high digit moves exactly on the edges its enable is high
	digit1_hold_a : assert property (@(posedge CLK) disable iff (!clr_rst_b)
		(clr_rst_b && !en1) |=> $stable(DIGIT1))
		else $error("high digit moved without cascade enable");

	digit1_step_a : assert property (@(posedge CLK) disable iff (!clr_rst_b)
		(clr_rst_b && en1) |=> !$stable(DIGIT1))
		else $error("high digit held despite cascade enable");

	wave_clear_a : assert property (@(posedge CLK)
		(!clr_rst_b && !$past(clr_rst_b)) |-> lfsr_state_bits_q == WAVE_START && !waveform_output_reg_q)
		else $error("waveform not at start during clear");

	status_wave_a : assert property (@(posedge CLK) disable iff (!RST_B)
		(RD && ADDR == ADDR_STATUS) |=> RDATA[STAT_WAVE_BIT] == $past(waveform_output_reg_q))
		else $error("status waveform bit wrong");

endmodule // seq_wave_gen

`default_nettype wire

// ### verilog/seq_wave_pkg.sv
// Notes on behaviour
// - synchronous four bit counter, configured code sequence
// - counter advances only while count enable high
// - no load; asynchronous clear at any time
// - all four counter bits visible as outputs
// - plain binary and reflected gray sixteen-state sequences
// - gray mode changes one bit per step
// - ten-state excess-three plain and reflected sequences
// - terminal count ANDed with enable feeds next digit
// - synchronous waveform pattern, length up to 32
// - waveform enable low freezes state and output
// - asynchronous clear restarts waveform from the beginning
// - five shift flip-flops with five-input feedback function
// - every state value leads into the cycle
// - second function is programmable per-state output table
// - output registered in sixth flop, one clock late
// - modulus 28 test pattern must be expressible
// - modulus 19 test pattern must be expressible
//
package seq_wave_pkg;

	// ********************************
	// sequence selection
	// ********************************
	typedef enum logic [1:0] {
		SEQ_BINARY                 = 2'h0,
		SEQ_GRAY                   = 2'h1,
		SEQ_EXCESS_THREE_PLAIN     = 2'h2,
		SEQ_EXCESS_THREE_REFLECTED = 2'h3
	} seq_mode_type;

	localparam logic [3:0]  LAST_FULL      = 4'hf;
	localparam logic [3:0]  LAST_DECADE    = 4'h9;
	localparam logic [3:0]  X3_OFFSET      = 4'h3;
	// reflected excess-three codes, index 0 in the low nibble
	localparam logic [39:0] X3_REFL_TBL    = 40'ha_e_f_d_c_4_5_7_6_2;
	localparam logic [4:0]  WAVE_START     = 5'h00;

	// ********************************
	// register map
	// ********************************
	localparam int          ADDR_W         = 4;
	localparam int          DATA_W         = 32;
	localparam logic [3:0]  ADDR_CNT_CTRL  = 4'h0;
	localparam logic [3:0]  ADDR_CNT_TC    = 4'h1;
	localparam logic [3:0]  ADDR_WAVE_LAST = 4'h2;
	localparam logic [3:0]  ADDR_WAVE_TBL  = 4'h3;
	localparam logic [3:0]  ADDR_STATUS    = 4'h4;
	localparam int          CTRL_DOWN_BIT  = 2;
	localparam int          STAT_SLOT_LSB  = 16;
	localparam int          STAT_WAVE_BIT  = 24;
	localparam seq_mode_type MODE_RST      = SEQ_BINARY;
	localparam logic [3:0]  TC_RST         = 4'hf;
	localparam logic [4:0]  WAVE_LAST_RST  = 5'h1f;
	localparam logic [31:0] WAVE_TBL_RST   = 32'h0000_0000;

	typedef struct packed {
		seq_mode_type mode;
		logic         down;
		logic [3:0]   tc1;
		logic [3:0]   tc0;
		logic [4:0]   last;
		logic [31:0]  table_bits;
	} cfg_type;

	// code of position idx in the chosen sequence
	function automatic logic [3:0] seq_code(input seq_mode_type m, input logic [3:0] idx);
		case (m)
			SEQ_BINARY:             seq_code = idx;
			SEQ_GRAY:               seq_code = idx ^ (idx >> 1);
			SEQ_EXCESS_THREE_PLAIN: seq_code = idx + X3_OFFSET;
			default:                seq_code = X3_REFL_TBL[{idx, 2'b00} +: 4];
		endcase
	endfunction

	function automatic logic [3:0] seq_last(input seq_mode_type m);
		seq_last = (m == SEQ_BINARY || m == SEQ_GRAY) ? LAST_FULL : LAST_DECADE;
	endfunction

	// de Bruijn feedback: maximal shift register extended by the all-zero state
	function automatic logic wave_fb(input logic [4:0] s);
		wave_fb = s[4] ^ s[2] ^ (s[3:0] == 4'h0);
	endfunction

endpackage

// ### verification/seq_ctl_model.sv
`timescale 1ns/10ps
`default_nettype none

// ********************************
// surrounding logic: enables and clear
// ********************************
module seq_ctl_model (
	input  wire logic clk,      // system clock
	input  wire logic rst_b,    // reset, low
	input  wire logic run_cnt,  // counter wanted
	input  wire logic run_wave, // waveform wanted
	input  wire logic stall,    // halve the enable rate
	input  wire logic clr_req,  // clear wanted
	output logic      cnt_en,   // counter enable
	output logic      wave_en,  // waveform enable
	output logic      clr_b     // clear, low
);
	logic ph_q;
	logic ph_d;

	// phase flop lives in the block's clock domain so enables meet its edge
	always_comb begin
		ph_d = ~ph_q;
	end
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			ph_q <= 1'b0;
		end else begin
			ph_q <= ph_d;
		end
	end

	// stall drops the enables on every other edge
	assign cnt_en  = run_cnt & (~stall | ph_q);
	assign wave_en = run_wave & (~stall | ph_q);
	// clear passes straight through: it must act between edges
	assign clr_b   = ~clr_req;
endmodule // seq_ctl_model
`default_nettype wire

// ### verification/seq_wave_gen_tb.sv
`timescale 1ns/10ps
`default_nettype none

module seq_wave_gen_tb;
	import seq_wave_pkg::*;
	logic        clk, rst_b, we, re, run_cnt, run_wave, stall, clr_req;
	logic        cnt_en, wave_en, clr_b, carry, wout;
	logic [3:0]  addr, d0, d1, tc0, tc1, p0;
	logic [31:0] wdata, rdata, tbl;
	logic [4:0]  lfsr, last, st, slot;
	logic [1:0]  m;
	logic        wv;
	int          i0, i1, miscompares, tests_run, cyc;
	logic [3:0]  xr [10] = '{4'h2, 4'h6, 4'h7, 4'h5, 4'h4, 4'hc, 4'hd, 4'hf, 4'he, 4'ha};

	seq_wave_gen seq_wave_gen_inst (.CLK(clk), .RST_B(rst_b), .CLR_B(clr_b), .CNT_EN(cnt_en),
		.WAVE_EN(wave_en), .ADDR(addr), .WDATA(wdata), .WR(we), .RD(re), .RDATA(rdata),
		.DIGIT0(d0), .DIGIT1(d1), .CARRY(carry), .LFSR_STATE(lfsr), .WAVE_OUT(wout));
	seq_ctl_model seq_ctl_model_inst (.clk(clk), .rst_b(rst_b), .run_cnt(run_cnt),
		.run_wave(run_wave), .stall(stall), .clr_req(clr_req), .cnt_en(cnt_en),
		.wave_en(wave_en), .clr_b(clr_b));

	// ********************************
	// reference sequences
	// ********************************
	function automatic logic [3:0] code(input int i);
		logic [3:0] v;
		v = 4'(i);
		if (i < 0) return 4'h0;
		case (m)
			2'h0: return v;
			2'h1: return v ^ (v >> 1);
			2'h2: return v + 4'h3;
			default: return xr[i];
		endcase
	endfunction
	function automatic int len();
		return (m < 2'h2) ? 16 : 10;
	endfunction
	function automatic int nx(input int i);
		return (i < 0 || i == len() - 1) ? 0 : i + 1;
	endfunction

	// reference state; ten-state modes leave 0000 for their first code
	always @(posedge clk or negedge rst_b or negedge clr_b) begin
		if (!rst_b || !clr_b) begin
			i0 = (m < 2'h2) ? 0 : -1;
			i1 = i0;
			st = 5'h00;
			slot = 5'h00;
			wv = 1'b0;
		end else begin
			if (cnt_en) begin
				if (code(i0) == tc0) i1 = nx(i1);
				i0 = nx(i0);
			end
			if (wave_en) begin
				wv = tbl[slot];
				st = (slot >= last) ? 5'h00 : {st[3:0], st[4] ^ st[2] ^ (st[3:0] == 4'h0)};
				slot = (slot >= last) ? 5'h00 : slot + 5'h01;
			end
		end
	end

	// ********************************
	// shared tasks
	// ********************************
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			miscompares++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge clk) begin addr <= a; wdata <= d; we <= 1'b1; end
		@(posedge clk) we <= 1'b0;
		if (a == ADDR_CNT_CTRL) m = d[1:0];
		if (a == ADDR_CNT_TC) {tc1, tc0} = d[7:0];
		if (a == ADDR_WAVE_LAST) last = d[4:0];
		if (a == ADDR_WAVE_TBL) tbl = d;
	endtask
	task automatic reg_rd(input logic [3:0] a, input logic [31:0] exp);
		@(posedge clk) begin addr <= a; re <= 1'b1; end
		@(posedge clk) re <= 1'b0;
		@(negedge clk) chk(rdata, exp);
		@(negedge clk) chk(rdata, 32'h0);
	endtask
	task automatic clear();
		@(posedge clk) clr_req <= 1'b1;
		@(posedge clk) clr_req <= 1'b0;
	endtask
	// every output except RDATA against the reference, each cycle
	task automatic run(input int n);
		p0 = d0;
		repeat (n) begin
			@(negedge clk);
			chk(d0, code(i0));
			chk(d1, code(i1));
			chk(carry, cnt_en & (code(i0) == tc0) & (code(i1) == tc1));
			chk(lfsr, st);
			chk(wout, wv);
			if (m[0] && d0 !== p0) chk(32'($countones(d0 ^ p0)), 32'h1);
			p0 = d0;
		end
	endtask
	function automatic logic [31:0] status();
		return {7'h0, wv, 3'h0, slot, 3'h0, st, code(i1), code(i0)};
	endfunction

	// ********************************
	// scenarios
	// ********************************
	task automatic t_regs();
		reg_rd(ADDR_CNT_CTRL, 32'h0);
		reg_rd(ADDR_CNT_TC, 32'hff);
		reg_rd(ADDR_WAVE_LAST, 32'h1f);
		reg_rd(ADDR_WAVE_TBL, 32'h0);
		reg_wr(4'h7, 32'hffff_ffff);
		reg_rd(4'h7, 32'h0);
		reg_wr(ADDR_STATUS, 32'hffff_ffff);
		reg_rd(ADDR_STATUS, status());
		$display("test regs done");
	endtask
	task automatic t_count();
		for (int k = 0; k < 4; k++) begin
			reg_wr(ADDR_CNT_CTRL, 32'(k));
			reg_wr(ADDR_CNT_TC, {24'h0, code(1), code(len() - 1)});
			clear();
			@(posedge clk) begin run_cnt <= 1'b1; stall <= k[0]; end
			run(70);
			@(posedge clk) run_cnt <= 1'b0;
			run(3);
			@(posedge clk) clr_req <= 1'b1;
			#1 chk(d0, 32'h0);
			@(posedge clk) clr_req <= 1'b0;
		end
		$display("test counter done");
	endtask
	task automatic t_wave(input logic [4:0] l, input logic [31:0] t, input logic s);
		reg_wr(ADDR_WAVE_LAST, {27'h0, l});
		reg_wr(ADDR_WAVE_TBL, t);
		reg_rd(ADDR_WAVE_LAST, {27'h0, l});
		reg_rd(ADDR_WAVE_TBL, t);
		clear();
		@(posedge clk) begin run_wave <= 1'b1; stall <= s; end
		run(2 * l + 9);
		@(posedge clk) clr_req <= 1'b1;
		#1 chk({lfsr, wout}, 32'h0);
		@(posedge clk) clr_req <= 1'b0;
		run(2 * l + 9);
		@(posedge clk) run_wave <= 1'b0;
		run(2);
		reg_rd(ADDR_STATUS, status());
		$display("test wave done");
	endtask

	// binary down count: low digit steps 0, f, e, ...; high digit follows tc0 = 0
	task automatic t_down();
		reg_wr(ADDR_CNT_CTRL, 32'h0000_0004);
		reg_wr(ADDR_CNT_TC, 32'h0000_00e0);
		reg_rd(ADDR_CNT_CTRL, 32'h0000_0004);
		reg_rd(ADDR_CNT_TC, 32'h0000_00e0);
		clear();
		@(posedge clk) begin run_cnt <= 1'b1; stall <= 1'b0; end
		for (int k = 0; k < 20; k++) begin
			@(negedge clk);
			chk(d0, 32'((32 - k) % 16));
			chk(d1, (k == 0) ? 32'h0 : ((k <= 16) ? 32'hf : 32'he));
		end
		@(posedge clk) run_cnt <= 1'b0;
		$display("test down done");
	endtask

	task automatic print_verdict();
		$display("comparisons %0d mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask

	// hang guard, well above the roughly 800 cycles the tests need
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			miscompares++;
			print_verdict();
		end
	end
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	initial begin
		logic [31:0] t28;
		logic [31:0] t19;
		{rst_b, we, re, run_cnt, run_wave, stall, clr_req} = 7'h0;
		{addr, wdata, miscompares, tests_run, cyc, m} = '0;
		{tc1, tc0, last, tbl} = {8'hff, 5'h1f, 32'h0};
		t28 = 32'h0fc0_040c; // slots 2, 3, 10, 22..27 high
		t19 = 32'h0007_ffff & ~32'h0004_9200; // slots 9, 12, 15, 18 low
		repeat (5) @(posedge clk);
		rst_b <= 1'b1;
		t_regs();
		t_count();
		t_down();
		t_wave(5'd27, t28, 1'b0);
		t_wave(5'd18, t19, 1'b1);
		t_wave(5'd31, 32'h9a3c_51e7, 1'b0);
		print_verdict();
	end
endmodule // seq_wave_gen_tb
`default_nettype wire
